// ### rco_mac_model.sv
// Behavioural model of the MAC receive path feeding the offload block
`timescale 1ns/10ps
`default_nettype none
module rco_mac_model (
  // Clock
  input wire logic clk_sys,
  // Byte stream towards the block
  output logic rx_valid,
  output rco_pkg::rco_rx_byte_type rx_byte
);
  import rco_pkg::*;
  // ==================================================
  // Frame bytes queued by the bench
  logic [7:0] frm[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = '0;
  end
  task automatic send(input bit slow);
    int n;
    n = frm.size();
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_byte <= '{data: frm[i], first: i == 0, last: i == n - 1};
      // Idle data inverted so a stale byte is never mistaken for a fresh one
      if (slow && i % 3 == 1 && i < n - 1) begin
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_byte.data <= ~frm[i];
      end
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte <= '{data: ~frm[n - 1], first: 1'b0, last: 1'b0};
    frm.delete();
  endtask
endmodule
`default_nettype wire

// ### rco_pkg.sv
// Types shared by the receive checksum offload block
`default_nettype none
package rco_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } rco_rx_byte_type;

  typedef struct packed {
    logic ip_csum_err;
    logic l4_csum_err;
    logic vlan_tagged;
    logic is_ipv4;
    logic is_ipv6;
  } rco_cmd_a_type;

  typedef struct packed {
    logic [15:0] raw_sum;
  } rco_cmd_b_type;

  typedef enum logic [1:0] {
    RCO_ST_MAC = 2'b00,
    RCO_ST_L3 = 2'b01,
    RCO_ST_SKIP = 2'b10
  } rco_state_type;
endpackage
`default_nettype wire

// ### rco_regs.svh
// Register offsets, field positions and constants of the receive checksum offload block
`ifndef RCO_REGS_SVH
`define RCO_REGS_SVH
// ==================================================
// Register offsets
`define RCO_OFS_CTL 8'h00
`define RCO_OFS_VLAN 8'h04
`define RCO_OFS_DPSEL 8'h08
`define RCO_OFS_DPADDR 8'h0c
`define RCO_OFS_DPDATA 8'h10
`define RCO_OFS_DPCMD 8'h14
`define RCO_OFS_STAT 8'h18
// ==================================================
// Fields and reset values
`define RCO_CTL_IP 0
`define RCO_CTL_TCP 1
`define RCO_CTL_ICMP 2
`define RCO_CTL_IGMP 3
`define RCO_DPCMD_WR 0
`define RCO_STAT_INIT 0
`define RCO_STAT_DP 1
`define RCO_CTL_RST 4'h0
`define RCO_VLAN_RST 16'h8100
`define RCO_DPSEL_RST 4'h0
`define RCO_DPSEL_RAM 4'h1
// ==================================================
// Filter RAM: 128 VLAN words then 16 hash words
`define RCO_RAM_WORDS 144
`define RCO_RAM_LAST 8'h8f
// ==================================================
// Frame parsing constants
`define RCO_TYPE_POS 16'h000c
`define RCO_VLAN_STEP 16'h0004
`define RCO_SNAP_STEP 16'h0008
`define RCO_TYPE_MIN 16'h0600
`define RCO_TYPE_IPV4 16'h0800
`define RCO_TYPE_IPV6 16'h86dd
`define RCO_MAX_TAGS 2'h2
`define RCO_MIN_IHL 4'h5
`define RCO_PROTO_TCP 8'h06
`define RCO_SUM_OK 16'hffff
`define RCO_OFF_TLEN_HI 16'h0002
`define RCO_OFF_TLEN_LO 16'h0003
`define RCO_OFF_FRAG_LO 16'h0007
`define RCO_OFF_PROTO 16'h0009
`define RCO_OFF_ADDR_LO 16'h000c
`define RCO_OFF_ADDR_HI 16'h0013
`define RCO_MF_BIT 5
`endif

// ### rco_rx_checksum_offload.sv
// Receive checksum offload with filter RAM, data port and register port
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "rco_regs.svh"
// ==================================================
// How it works
// - Filter RAM holds VLAN and hash tables, words
// - Data port reaches RAM when selected, anytime after clear
// - RAM cleared after reset, port waits meanwhile
// - Parse Type II and SNAP frames
// - Up to two tags of programmable type skipped
// - 0800h is IPv4, 86DDh IPv6 unchecked
// - Bad IPv4 header sum flags error, aborts
// - Header length under 20 bytes is error
// - Header sum including checksum must be FFFFh
// - Raw sum computed when any L4 enable
// - Raw sum little-endian halfwords, odd zero-padded
// - Carries wrap back into the sum
// - Raw sum starts after final type field
// - Raw sum reported in second command word
// - Protocol 6 with enable means TCP check
// - Pseudo header with computed segment length
// - Odd TCP length padded with zero byte
// - TCP sum not FFFFh sets L4 error
// - Fragments skip the TCP check
// - L4-failing frames still delivered, status only
module rco_rx_checksum_offload (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Receive byte stream from the MAC, frame check sequence already removed
  input wire logic rx_valid,
  input wire rco_pkg::rco_rx_byte_type rx_byte,
  // Command words to the frame FIFO controller
  output logic cmd_valid,
  output rco_pkg::rco_cmd_a_type cmd_a,
  output rco_pkg::rco_cmd_b_type cmd_b,
  output logic frame_abort
);
  import rco_pkg::*;
  // ==================================================
  // End-around-carry halfword add
  function automatic logic [15:0] add1c(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    add1c = s[15:0] + {15'h0000, s[16]};
  endfunction
  // ==================================================
  // Control registers, data port and filter RAM
  logic [3:0] ctl_r, ctl_nxt;
  logic [15:0] vlan_tag_type_value_r, vlan_tag_type_value_nxt;
  logic [3:0] data_port_ram_select_r, data_port_ram_select_nxt;
  logic [7:0] dp_addr_r, dp_addr_nxt;
  logic [31:0] dp_data_r, dp_data_nxt;
  logic dp_pend_r, dp_pend_nxt;
  logic dp_wr_r, dp_wr_nxt;
  logic init_busy_r, init_busy_nxt;
  logic [7:0] init_idx_r, init_idx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] ram_r [`RCO_RAM_WORDS];
  logic ram_we;
  logic [7:0] ram_idx;
  logic [31:0] ram_wd;
  logic dp_exec;
  logic dp_ram;
  always_comb begin
    ctl_nxt = ctl_r;
    vlan_tag_type_value_nxt = vlan_tag_type_value_r;
    data_port_ram_select_nxt = data_port_ram_select_r;
    dp_addr_nxt = dp_addr_r;
    dp_data_nxt = dp_data_r;
    dp_pend_nxt = dp_pend_r;
    dp_wr_nxt = dp_wr_r;
    init_busy_nxt = init_busy_r;
    init_idx_nxt = init_idx_r;
    rdata_nxt = 32'h0000_0000;
    ram_we = 1'b0;
    ram_idx = init_idx_r;
    ram_wd = 32'h0000_0000;
    dp_ram = (data_port_ram_select_r == `RCO_DPSEL_RAM) && (dp_addr_r <= `RCO_RAM_LAST);
    // port held off while the clear runs
    dp_exec = dp_pend_r && !init_busy_r;
    if (init_busy_r) begin
      ram_we = 1'b1;
      init_idx_nxt = init_idx_r + 8'h01;
      init_busy_nxt = (init_idx_r != `RCO_RAM_LAST);
    end else if (dp_exec) begin
      // data port access, traffic keeps running
      dp_pend_nxt = 1'b0;
      ram_idx = dp_addr_r;
      ram_wd = dp_data_r;
      ram_we = dp_wr_r && dp_ram;
      dp_data_nxt = dp_wr_r ? dp_data_r : (dp_ram ? ram_r[dp_addr_r] : 32'h0000_0000);
    end
    if (reg_wr) begin
      case (reg_addr)
        `RCO_OFS_CTL: ctl_nxt = reg_wdata[3:0];
        `RCO_OFS_VLAN: vlan_tag_type_value_nxt = reg_wdata[15:0];
        `RCO_OFS_DPSEL: data_port_ram_select_nxt = reg_wdata[3:0];
        `RCO_OFS_DPADDR: dp_addr_nxt = reg_wdata[7:0];
        `RCO_OFS_DPDATA: dp_data_nxt = reg_wdata;
        `RCO_OFS_DPCMD: begin
          dp_pend_nxt = 1'b1;
          dp_wr_nxt = reg_wdata[`RCO_DPCMD_WR];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `RCO_OFS_CTL: rdata_nxt = {28'h0000000, ctl_r};
        `RCO_OFS_VLAN: rdata_nxt = {16'h0000, vlan_tag_type_value_r};
        `RCO_OFS_DPSEL: rdata_nxt = {28'h0000000, data_port_ram_select_r};
        `RCO_OFS_DPADDR: rdata_nxt = {24'h000000, dp_addr_r};
        `RCO_OFS_DPDATA: rdata_nxt = dp_data_r;
        `RCO_OFS_DPCMD: rdata_nxt = {31'h00000000, dp_wr_r};
        `RCO_OFS_STAT: rdata_nxt = {30'h00000000, dp_pend_r, init_busy_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= `RCO_CTL_RST;
      vlan_tag_type_value_r <= `RCO_VLAN_RST;
      data_port_ram_select_r <= `RCO_DPSEL_RST;
      dp_addr_r <= 8'h00;
      dp_data_r <= 32'h0000_0000;
      dp_pend_r <= 1'b0;
      dp_wr_r <= 1'b0;
      init_busy_r <= 1'b1;
      init_idx_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctl_r <= ctl_nxt;
      vlan_tag_type_value_r <= vlan_tag_type_value_nxt;
      data_port_ram_select_r <= data_port_ram_select_nxt;
      dp_addr_r <= dp_addr_nxt;
      dp_data_r <= dp_data_nxt;
      dp_pend_r <= dp_pend_nxt;
      dp_wr_r <= dp_wr_nxt;
      init_busy_r <= init_busy_nxt;
      init_idx_r <= init_idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  // one word-addressed store for both tables; no reset, the walk clears it
  always_ff @(posedge clk_sys) begin
    if (ram_we)
      ram_r[ram_idx] <= ram_wd;
  end
  assign reg_rdata = rdata_r;
  // ==================================================
  // Frame parser and checksum accumulators
  rco_state_type st_r, st_nxt;
  logic [15:0] pos_r, pos_nxt, type_pos_r, type_pos_nxt, off_r, off_nxt;
  logic [1:0] tags_r, tags_nxt;
  logic [7:0] hold_r, hold_nxt, proto_r, proto_nxt;
  logic is4_r, is4_nxt, is6_r, is6_nxt;
  logic [3:0] ihl_r, ihl_nxt;
  logic [15:0] tlen_r, tlen_nxt;
  logic frag_r, frag_nxt;
  logic [15:0] raw_r, raw_nxt, ip_r, ip_nxt, l4_r, l4_nxt;
  logic [7:0] tail_r, tail_nxt;
  logic tail_odd_r, tail_odd_nxt;
  logic [15:0] pos, hlen, ttype, raw_fin, ip_fin, l4_fin, l4_pad;
  logic fin, ip_err, l4_err;
  logic cmd_valid_r, abort_r;
  rco_cmd_a_type cmd_a_r, cmd_a_nxt;
  rco_cmd_b_type cmd_b_r, cmd_b_nxt;
  always_comb begin
    st_nxt = st_r;
    pos_nxt = pos_r;
    type_pos_nxt = type_pos_r;
    off_nxt = off_r;
    tags_nxt = tags_r;
    hold_nxt = hold_r;
    proto_nxt = proto_r;
    is4_nxt = is4_r;
    is6_nxt = is6_r;
    ihl_nxt = ihl_r;
    tlen_nxt = tlen_r;
    frag_nxt = frag_r;
    raw_nxt = raw_r;
    ip_nxt = ip_r;
    l4_nxt = l4_r;
    tail_nxt = tail_r;
    tail_odd_nxt = tail_odd_r;
    cmd_a_nxt = cmd_a_r;
    cmd_b_nxt = cmd_b_r;
    fin = rx_valid && rx_byte.last;
    pos = rx_byte.first ? 16'h0000 : pos_r;
    hlen = {10'h000, ihl_r, 2'b00};
    ttype = {hold_r, rx_byte.data};
    raw_fin = raw_r;
    ip_fin = ip_r;
    l4_fin = l4_r;
    l4_pad = 16'h0000;
    if (rx_valid) begin
      pos_nxt = pos + 16'h0001;
      if (rx_byte.first) begin
        st_nxt = RCO_ST_MAC;
        type_pos_nxt = `RCO_TYPE_POS;
        tags_nxt = 2'h0;
        is4_nxt = 1'b0;
        is6_nxt = 1'b0;
        ihl_nxt = 4'h0;
        tlen_nxt = 16'h0000;
        frag_nxt = 1'b0;
        proto_nxt = 8'h00;
        raw_nxt = 16'h0000;
        ip_nxt = 16'h0000;
        l4_nxt = 16'h0000;
        tail_odd_nxt = 1'b0;
        cmd_a_nxt = '0;
      end
      case (st_nxt)
        RCO_ST_MAC: begin
          if (pos == type_pos_nxt) begin
            hold_nxt = rx_byte.data;
          end else if (pos == type_pos_nxt + 16'h0001) begin
            if (ttype == vlan_tag_type_value_r && tags_nxt != `RCO_MAX_TAGS) begin
              tags_nxt = tags_nxt + 2'h1;
              type_pos_nxt = type_pos_nxt + `RCO_VLAN_STEP;
              cmd_a_nxt.vlan_tagged = 1'b1;
            // length field means LLC/SNAP header follows
            end else if (ttype < `RCO_TYPE_MIN) begin
              type_pos_nxt = type_pos_nxt + `RCO_SNAP_STEP;
            end else begin
              is4_nxt = (ttype == `RCO_TYPE_IPV4);
              is6_nxt = (ttype == `RCO_TYPE_IPV6);
              cmd_a_nxt.is_ipv4 = is4_nxt;
              cmd_a_nxt.is_ipv6 = is6_nxt;
              // raw sum begins with the next byte
              st_nxt = RCO_ST_L3;
              off_nxt = 16'h0000;
            end
          end
        end
        RCO_ST_L3: begin
          off_nxt = off_r + 16'h0001;
          if (!off_r[0]) begin
            hold_nxt = rx_byte.data;
            // odd final byte pairs with zero high byte
            raw_fin = add1c(raw_r, {8'h00, rx_byte.data});
          end else begin
            // even byte low, odd byte high
            raw_nxt = add1c(raw_r, {rx_byte.data, hold_r});
            raw_fin = raw_nxt;
            // big-endian header halfwords incl. stored sum
            if (off_r < hlen)
              ip_nxt = add1c(ip_r, ttype);
            if ((off_r >= `RCO_OFF_ADDR_LO && off_r <= `RCO_OFF_ADDR_HI) ||
                (off_r >= hlen && off_r < tlen_r))
              l4_nxt = add1c(l4_r, ttype);
          end
          if (off_r == 16'h0000)
            ihl_nxt = rx_byte.data[3:0];
          if (off_r == `RCO_OFF_TLEN_HI)
            tlen_nxt = {rx_byte.data, 8'h00};
          if (off_r == `RCO_OFF_TLEN_LO)
            tlen_nxt = {tlen_r[15:8], rx_byte.data};
          if (off_r == `RCO_OFF_FRAG_LO)
            frag_nxt = hold_r[`RCO_MF_BIT] || ({hold_r[4:0], rx_byte.data} != 13'h0000);
          if (off_r == `RCO_OFF_PROTO)
            proto_nxt = rx_byte.data;
          // remember an unpaired last segment byte
          if (!off_r[0] && off_r >= hlen && off_r + 16'h0001 == tlen_r) begin
            tail_nxt = rx_byte.data;
            tail_odd_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    ip_fin = ip_nxt;
    // zero byte appended after the last data byte
    l4_pad = tail_odd_nxt ? {tail_nxt, 8'h00} : 16'h0000;
    // protocol plus total length minus four times header length
    l4_fin = add1c(add1c(add1c(l4_nxt, l4_pad), {8'h00, proto_nxt}),
                   tlen_nxt - {10'h000, ihl_nxt, 2'b00});
    // header checked only when enabled; short header always bad
    ip_err = ctl_r[`RCO_CTL_IP] && is4_nxt && (ihl_nxt < `RCO_MIN_IHL || ip_fin != `RCO_SUM_OK);
    // TCP over IPv4; anything but FFFFh fails
    l4_err = ctl_r[`RCO_CTL_TCP] && is4_nxt && proto_nxt == `RCO_PROTO_TCP &&
             !frag_nxt && ihl_nxt >= `RCO_MIN_IHL && l4_fin != `RCO_SUM_OK;
    if (fin) begin
      // error bits and raw sum settle on the last byte
      cmd_a_nxt.ip_csum_err = ip_err;
      cmd_a_nxt.l4_csum_err = l4_err;
      // computed always, so valid with any L4 enable
      // raw sum into the second command word
      cmd_b_nxt.raw_sum = (st_nxt == RCO_ST_L3) ? raw_fin : 16'h0000;
      st_nxt = RCO_ST_SKIP;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= RCO_ST_SKIP;
      pos_r <= 16'h0000;
      type_pos_r <= `RCO_TYPE_POS;
      off_r <= 16'h0000;
      tags_r <= 2'h0;
      hold_r <= 8'h00;
      proto_r <= 8'h00;
      is4_r <= 1'b0;
      is6_r <= 1'b0;
      ihl_r <= 4'h0;
      tlen_r <= 16'h0000;
      frag_r <= 1'b0;
      raw_r <= 16'h0000;
      ip_r <= 16'h0000;
      l4_r <= 16'h0000;
      tail_r <= 8'h00;
      tail_odd_r <= 1'b0;
      cmd_valid_r <= 1'b0;
      abort_r <= 1'b0;
      cmd_a_r <= '0;
      cmd_b_r <= '0;
    end else begin
      st_r <= st_nxt;
      pos_r <= pos_nxt;
      type_pos_r <= type_pos_nxt;
      off_r <= off_nxt;
      tags_r <= tags_nxt;
      hold_r <= hold_nxt;
      proto_r <= proto_nxt;
      is4_r <= is4_nxt;
      is6_r <= is6_nxt;
      ihl_r <= ihl_nxt;
      tlen_r <= tlen_nxt;
      frag_r <= frag_nxt;
      raw_r <= raw_nxt;
      ip_r <= ip_nxt;
      l4_r <= l4_nxt;
      tail_r <= tail_nxt;
      tail_odd_r <= tail_odd_nxt;
      cmd_valid_r <= fin;
      // abort goes out beside the erroring command words
      abort_r <= fin && ip_err;
      cmd_a_r <= cmd_a_nxt;
      cmd_b_r <= cmd_b_nxt;
    end
  end
  assign cmd_valid = cmd_valid_r;
  assign cmd_a = cmd_a_r;
  assign cmd_b = cmd_b_r;
  assign frame_abort = abort_r;
  // ==================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence seq_dp_req;
    reg_wr && reg_addr == `RCO_OFS_DPCMD ##1 dp_pend_r;
  endsequence
  chk_dp_completes: assert property (seq_dp_req |-> ##[0:200] !dp_pend_r)
    else $error("data port command never completed");
  chk_dp_wait_init: assert property (init_busy_r && dp_pend_r |=> dp_pend_r)
    else $error("data port ran during RAM clear");
  chk_init_walk: assert property (init_busy_r && init_idx_r != `RCO_RAM_LAST
      |=> init_busy_r && init_idx_r == $past(init_idx_r) + 8'h01)
    else $error("RAM clear walk skipped a word");
  chk_abort_pair: assert property (frame_abort |-> cmd_valid && cmd_a.ip_csum_err)
    else $error("abort without IP checksum error");
  chk_short_hdr: assert property (fin && is4_nxt && ctl_r[`RCO_CTL_IP] &&
      ihl_nxt < `RCO_MIN_IHL |=> cmd_valid && cmd_a.ip_csum_err && frame_abort)
    else $error("short IPv4 header not flagged");
  chk_ipv6_no_ip: assert property (cmd_valid && cmd_a.is_ipv6 |-> !cmd_a.ip_csum_err)
    else $error("IPv6 frame flagged with IP error");
  chk_frag_skip: assert property (fin && frag_nxt |=> cmd_valid && !cmd_a.l4_csum_err)
    else $error("fragment got an L4 error");
  chk_raw_report: assert property (fin && st_r == RCO_ST_L3
      |=> cmd_b.raw_sum == $past(raw_fin))
    else $error("raw sum not reported");
  chk_one_result: assert property (cmd_valid |-> $past(fin) && !$past(cmd_valid))
    else $error("result without a frame end");
  chk_vlan_skip: assert property (rx_valid && st_nxt == RCO_ST_MAC && st_r == RCO_ST_MAC &&
      !rx_byte.first && pos == type_pos_r + 16'h0001 && ttype == vlan_tag_type_value_r &&
      tags_r != `RCO_MAX_TAGS && !fin
      |=> type_pos_r == $past(type_pos_r) + `RCO_VLAN_STEP)
    else $error("VLAN tag not skipped");
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the receive checksum offload block
`timescale 1ns/10ps
`default_nettype none
`include "rco_regs.svh"
module tb;
  import rco_pkg::*;
  // ==================================================
  // Signals
  logic clk_sys = 1'b0;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic rx_valid;
  rco_rx_byte_type rx_byte;
  logic cmd_valid;
  logic frame_abort;
  rco_cmd_a_type cmd_a;
  rco_cmd_b_type cmd_b;
  int error_cnt = 0;
  int checks_done = 0;
  int res_cnt = 0;
  int frames = 0;
  logic [7:0] l3[$];
  logic [31:0] rd;
  logic [15:0] tag_type = 16'h8100;
  always #5 clk_sys = ~clk_sys;
  rco_rx_checksum_offload DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_valid(cmd_valid), .cmd_a(cmd_a),
    .cmd_b(cmd_b), .frame_abort(frame_abort));
  rco_mac_model mac (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte));
  always @(posedge clk_sys) if (cmd_valid === 1'b1) res_cnt++;
  // ==================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = a + b;
    return s[15:0] + 16'(s[16]);
  endfunction
  // Sum of l3 bytes; le selects low-byte-first pairing, odd tail padded with zero
  function automatic logic [15:0] sum(input int lo, input int hi, input bit le);
    logic [15:0] s;
    logic [7:0] nb;
    s = 16'h0000;
    for (int i = lo; i < hi; i += 2) begin
      nb = (i + 1 < hi) ? l3[i + 1] : 8'h00;
      s = oc_add(s, le ? {nb, l3[i]} : {l3[i], nb});
    end
    return s;
  endfunction
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic dp_cmd(input logic [31:0] dir);
    int k;
    reg_write(`RCO_OFS_DPCMD, dir);
    k = 0;
    rd = 32'h0000_0002;
    while (rd[1] !== 1'b0) begin
      reg_read(`RCO_OFS_STAT);
      k++;
      if (k > 200) begin
        error_cnt++;
        stop_test();
      end
    end
  endtask
  // IPv4 header plus TCP segment with nd data bytes; frag 1 first piece, 2 later piece
  task automatic mk_ip(input logic [3:0] ihl, input int nd, input bit bad_ip, input bit bad_tcp,
                       input int frag);
    logic [15:0] tl;
    logic [15:0] s;
    tl = 16'(40 + nd);
    l3 = '{{4'h4, ihl}, 8'h00, tl[15:8], tl[7:0], 8'h00, 8'h00, (frag == 1) ? 8'h20 : 8'h00,
           (frag == 2) ? 8'h01 : 8'h00, 8'h40, 8'h06, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00,
           8'h01, 8'h0a, 8'h00, 8'h00, 8'h02};
    for (int i = 0; i < 20 + nd; i++) l3.push_back(8'(i * 7 + 3));
    l3[36] = 8'h00;
    l3[37] = 8'h00;
    s = ~sum(0, 20, 1'b0) ^ 16'(bad_ip);
    l3[10] = s[15:8];
    l3[11] = s[7:0];
    s = oc_add(oc_add(sum(12, 20, 1'b0), 16'h0006), 16'(20 + nd));
    s = ~oc_add(s, sum(20, 40 + nd, 1'b0)) ^ 16'(bad_tcp);
    l3[36] = s[15:8];
    l3[37] = s[7:0];
  endtask
  task automatic run_frame(input int tags, input bit snap, input logic [15:0] et,
                           input bit slow, input bit e_ip, input bit e_l4, input bit c_l4);
    logic [15:0] raw;
    int k;
    for (int i = 0; i < 12; i++) mac.frm.push_back(8'(i + 16));
    for (int t = 0; t < tags; t++) mac.frm = {mac.frm, tag_type[15:8], tag_type[7:0], 8'h00, 8'(t + 5)};
    if (snap) mac.frm = {mac.frm, 8'h00, 8'h40, 8'haa, 8'haa, 8'h03, 8'h00, 8'h00, 8'h00};
    mac.frm = {mac.frm, et[15:8], et[7:0], l3};
    raw = sum(0, l3.size(), 1'b1);
    mac.send(slow);
    frames++;
    #1;
    k = 0;
    while (cmd_valid !== 1'b1) begin
      if (k == 10) begin
        error_cnt++;
        stop_test();
      end
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("ip error", cmd_a.ip_csum_err, e_ip); // header verdict
    check("abort", frame_abort, e_ip); // abort only on header error
    if (c_l4) check("l4 error", cmd_a.l4_csum_err, e_l4); // segment verdict
    check("tagged", cmd_a.vlan_tagged, tags > 0); // tag seen
    check("ipv4", cmd_a.is_ipv4, et == 16'h0800); // class
    check("ipv6", cmd_a.is_ipv6, et == 16'h86dd); // class
    check("raw sum", cmd_b.raw_sum, raw); // raw sum value
  endtask
  // ==================================================
  // Scenarios
  task automatic t_regs();
    reg_read(`RCO_OFS_STAT);
    check("init busy", rd[0], 1'b1); // clearing runs
    reg_read(`RCO_OFS_VLAN);
    check("tag type", rd, 32'h0000_8100); // default
    reg_read(8'h40);
    check("unmapped", rd, 32'h0); // unmapped reads zero
    reg_write(`RCO_OFS_CTL, 32'hffff_ffff);
    reg_read(`RCO_OFS_CTL);
    check("ctl", rd, 32'h0000_000f); // enables
    $display("test regs done");
  endtask
  task automatic t_dp();
    reg_write(`RCO_OFS_DPSEL, 32'h1);
    reg_write(`RCO_OFS_DPADDR, 32'h5);
    reg_write(`RCO_OFS_DPDATA, 32'h1234_abcd);
    reg_write(`RCO_OFS_DPCMD, 32'h1);
    reg_read(`RCO_OFS_STAT);
    check("held off", rd[1:0], 2'b11); // wait stated
    dp_cmd(32'h1);
    reg_write(`RCO_OFS_DPDATA, 32'h0);
    dp_cmd(32'h0);
    reg_read(`RCO_OFS_DPDATA);
    check("dp word", rd, 32'h1234_abcd); // word kept
    reg_write(`RCO_OFS_DPADDR, 32'h8f);
    dp_cmd(32'h0);
    reg_read(`RCO_OFS_DPDATA);
    check("cleared", rd, 32'h0); // zero after clear
    reg_write(`RCO_OFS_DPDATA, 32'h5a5a_0f0f);
    dp_cmd(32'h1);
    reg_write(`RCO_OFS_DPDATA, 32'h0);
    dp_cmd(32'h0);
    reg_read(`RCO_OFS_DPDATA);
    check("hash word", rd, 32'h5a5a_0f0f); // last hash word
    $display("test data port done");
  endtask
  task automatic t_ip();
    mk_ip(4'h5, 5, 1'b0, 1'b0, 0);
    run_frame(2, 1'b0, 16'h0800, 1'b1, 1'b0, 1'b0, 1'b1);
    mk_ip(4'h5, 6, 1'b1, 1'b0, 0);
    run_frame(0, 1'b0, 16'h0800, 1'b0, 1'b1, 1'b0, 1'b1);
    mk_ip(4'h4, 6, 1'b0, 1'b0, 0);
    run_frame(0, 1'b0, 16'h0800, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("test ip done");
  endtask
  task automatic t_tcp();
    mk_ip(4'h5, 4, 1'b0, 1'b1, 0);
    run_frame(1, 1'b1, 16'h0800, 1'b0, 1'b0, 1'b1, 1'b1);
    // both fragment forms skip the check
    for (int f = 1; f < 3; f++) begin
      mk_ip(4'h5, 4, 1'b0, 1'b1, f);
      run_frame(0, 1'b0, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    l3.delete();
    for (int i = 0; i < 41; i++) l3.push_back(8'(i * 13 + 1));
    run_frame(0, 1'b1, 16'h86dd, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test tcp done");
  endtask
  task automatic t_enables();
    logic [3:0] ctl[3];
    ctl = '{4'h0, 4'h4, 4'h8};
    reg_write(`RCO_OFS_VLAN, 32'h0000_9100);
    tag_type = 16'h9100;
    foreach (ctl[i]) begin
      reg_write(`RCO_OFS_CTL, 32'(ctl[i]));
      mk_ip(4'h5, 3, 1'b1, 1'b1, 0);
      run_frame(1, 1'b0, 16'h0800, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    $display("test enables done");
  endtask
  task automatic t_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_read(`RCO_OFS_STAT);
    check("init again", rd[0], 1'b1); // clear after any reset
    reg_write(`RCO_OFS_DPSEL, 32'h1);
    reg_write(`RCO_OFS_DPADDR, 32'h8f);
    dp_cmd(32'h0);
    reg_read(`RCO_OFS_DPDATA);
    check("cleared again", rd, 32'h0); // written word zeroed again
    $display("test reset done");
  endtask
  // ==================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_dp();
    t_ip();
    t_tcp();
    t_enables();
    t_reset();
    check("results", res_cnt, frames); // one result per frame
    stop_test();
  end
endmodule
`default_nettype wire
